// ---- shared/pfpc_pkg.sv ----
// package for the pin function and pad control block
package pfpc_pkg;

	// ==================================================
	// sizes
	localparam int PFPC_NPINS = 14;
	localparam int PFPC_AW    = 4;

	// ==================================================
	// register offsets
	localparam logic [3:0] PFPC_REG_SYSOPT    = 4'h0;
	localparam logic [3:0] PFPC_REG_FORCE_RST = 4'h1;
	localparam logic [3:0] PFPC_REG_STATUS    = 4'h2;
	localparam logic [3:0] PFPC_REG_PULL_EN   = 4'h4;
	localparam logic [3:0] PFPC_REG_DRIVE_HI  = 4'h5;
	localparam logic [3:0] PFPC_REG_SLEW_EN   = 4'h6;
	localparam logic [3:0] PFPC_REG_OUT_ONLY  = 4'h7;

	// ==================================================
	// field positions
	localparam int PFPC_BIT_RESET_PIN_EN = 0;
	localparam int PFPC_BIT_DEBUG_PIN_EN = 1;
	localparam int PFPC_BIT_FORCE_DBG    = 0;

	// ==================================================
	// pin indices and reset values
	localparam int PFPC_PIN_RESET_SHARED = 5;
	localparam int PFPC_PIN_DEBUG_SHARED = 4;
	localparam int PFPC_PIN_OUT_ONLY     = 13;
	localparam logic [13:0] PFPC_PULL_RST  = 14'h0000;
	localparam logic [13:0] PFPC_DRIVE_RST = 14'h0000;
	localparam logic [13:0] PFPC_SLEW_RST  = 14'h2000;
	localparam logic        PFPC_OUT_ONLY_EN_RST = 1'b0;

	// ==================================================
	// reset stretch (internal reset held this long)
	localparam int PFPC_RST_HOLD_NS  = 100;
	localparam int PFPC_CLK_NS       = 4;
	localparam int PFPC_RST_HOLD_CYC = (PFPC_RST_HOLD_NS + PFPC_CLK_NS - 1) / PFPC_CLK_NS;
	localparam int PFPC_BIT_CYC      = 16;

	typedef enum logic [1:0] {
		PFPC_RST_IDLE  = 2'b00,
		PFPC_RST_HOLD  = 2'b01,
		PFPC_RST_SAMPLE = 2'b10
	} pfpc_rst_state_t;

	// per-pin peripheral request bundle
	typedef struct packed {
		logic [13:0] port_oe;
		logic [13:0] periph_oe;
		logic [13:0] analog_en;
		logic [13:0] kbi_rising;
	} pfpc_pin_req_t;

	// per-pin pad controls
	typedef struct packed {
		logic [13:0] pull_on;
		logic [13:0] pull_down;
		logic [13:0] drive_hi;
		logic [13:0] slew_en;
	} pfpc_pad_ctl_t;

endpackage : pfpc_pkg

// ---- rtl/pfpc_sync2.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pfpc_sync2 #(
	parameter int W = 1
) (
	input  wire logic         ref_clk_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			meta <= '1;
			q_o  <= '1;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule // pfpc_sync2

// ---- rtl/pfpc_pull_gate.sv ----
// per-pin pull device gating
`timescale 1ns/1ps
module pfpc_pull_gate
	import pfpc_pkg::*;
(
	input  wire logic                  pull_en_i,
	input  wire logic                  port_oe_i,
	input  wire logic                  periph_oe_i,
	input  wire logic                  analog_i,
	input  wire logic                  kbi_rise_i,
	input  wire logic                  forced_i,
	output logic                       pull_on_o,
	output logic                       pull_down_o
);
	// forced pullups for the shared reset and debug pins win
	always_comb begin
		pull_on_o   = forced_i | (pull_en_i & ~port_oe_i & ~periph_oe_i & ~analog_i);
		pull_down_o = ~forced_i & pull_on_o & kbi_rise_i;
	end
endmodule // pfpc_pull_gate

// ---- rtl/pfpc_top.sv ----
// pin function and pad control: shared reset and debug pins, pad options
`timescale 1ns/1ps
module pfpc_top
	import pfpc_pkg::*;
(
	input  wire logic                  ref_clk_i,
	input  wire logic                  rst_b_i,
	input  wire logic                  por_b_i,
	// register port
	input  wire logic [PFPC_AW-1:0]    addr_i,
	input  wire logic [7:0]            wdata_i,
	input  wire logic                  wr_i,
	input  wire logic                  rd_i,
	output logic      [7:0]            rdata_o,
	// reset/irq/timer-clock shared pin
	input  wire logic                  reset_pin_i,
	input  wire logic                  irq_en_i,
	input  wire logic                  tclk_en_i,
	output logic                       reset_pin_is_reset_o,
	output logic                       port_a_bit_five_o,
	// debug/mode select pin (three signals)
	input  wire logic                  debug_mode_select_pin_i,
	output logic                       debug_mode_select_pin_o,
	output logic                       debug_mode_select_pin_oe_o,
	input  wire logic                  bdc_drive_i,
	input  wire logic                  bdc_drive_level_i,
	input  wire logic                  comparator_output_en_i,
	input  wire logic                  comparator_output_i,
	input  wire logic                  port_a_bit_four_oe_i,
	input  wire logic                  port_a_bit_four_data_i,
	output logic                       port_a_bit_four_o,
	output logic                       debug_rx_o,
	output logic                       debug_bit_tick_o,
	// per-pin requests from port and peripherals
	input  wire pfpc_pin_req_t         pin_req_i,
	output pfpc_pad_ctl_t              pad_ctl_o,
	// system reset and mode
	output logic                       sys_rst_b_o,
	output logic                       background_debug_state_o,
	output logic                       out_only_en_o
);

	// ==================================================
	// pin synchronisers
	logic [2:0] pins_s;
	pfpc_sync2 #(.W(3)) u_sync (
		.ref_clk_i (ref_clk_i),
		.rst_b_i   (rst_b_i),
		.d_i       ({por_b_i, reset_pin_i, debug_mode_select_pin_i}),
		.q_o       (pins_s)
	);
	logic por_b_s;
	logic reset_pin_s;
	logic mode_select_input;
	assign por_b_s           = pins_s[2];
	assign reset_pin_s       = pins_s[1];
	assign mode_select_input = pins_s[0];

	// ==================================================
	// control registers
	logic        reset_pin_enable;
	logic        debug_pin_enable;
	logic [13:0] pull_en;
	logic [13:0] drive_hi;
	logic [13:0] slew_en;
	logic        out_only_en;
	logic        force_debug_reset_bit;
	logic        por_seen;
	logic        ext_rst_req;
	pfpc_rst_state_t rst_state;
	logic [7:0]  hold_cnt;
	logic        hold_is_mode;

	logic wr_sysopt;
	logic wr_force;
	assign wr_sysopt = wr_i && addr_i == PFPC_REG_SYSOPT;
	assign wr_force  = wr_i && addr_i == PFPC_REG_FORCE_RST && wdata_i[PFPC_BIT_FORCE_DBG];

	// external reset request only when the pin is in reset function
	assign ext_rst_req = reset_pin_enable & ~reset_pin_s;

	// reset pin enable: only rst_b_i and power-on clear it, once set writes are ignored
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || !por_b_s) begin
			reset_pin_enable <= 1'b0;
		end else if (wr_sysopt && wdata_i[PFPC_BIT_RESET_PIN_EN]) begin
			reset_pin_enable <= 1'b1;
		end
	end

	// debug pin enable: set on any reset including internal ones
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || !sys_rst_b_o) begin
			debug_pin_enable <= 1'b1;
		end else if (wr_sysopt) begin
			debug_pin_enable <= wdata_i[PFPC_BIT_DEBUG_PIN_EN];
		end
	end

	// pad options, reset defaults on every reset
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || !sys_rst_b_o) begin
			pull_en     <= PFPC_PULL_RST;
			drive_hi    <= PFPC_DRIVE_RST;
			slew_en     <= PFPC_SLEW_RST;
			out_only_en <= PFPC_OUT_ONLY_EN_RST;
		end else if (wr_i) begin
			// per pin, independent of port data/direction
			case (addr_i)
				PFPC_REG_PULL_EN:  pull_en  <= {pull_en[13:8], wdata_i};
				PFPC_REG_DRIVE_HI: drive_hi <= {drive_hi[13:8], wdata_i};
				PFPC_REG_SLEW_EN:  slew_en  <= {slew_en[13:8], wdata_i};
				PFPC_REG_OUT_ONLY: begin
					// upper six pins share this register with the output-only enable
					pull_en[13:8]  <= {1'b0, wdata_i[4:0]};
					drive_hi[13:8] <= {wdata_i[6], drive_hi[12:8]};
					slew_en[13:8]  <= {wdata_i[5], slew_en[12:8]};
					out_only_en    <= wdata_i[7];
				end
				default: ;
			endcase
		end
	end

	// ==================================================
	// reset sequencer: stretches reset and samples mode select at release
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			rst_state                <= PFPC_RST_HOLD;
			hold_cnt                 <= 8'h00;
			hold_is_mode             <= 1'b1;
			sys_rst_b_o              <= 1'b0;
			background_debug_state_o <= 1'b0;
			force_debug_reset_bit    <= 1'b0;
			por_seen                 <= 1'b0;
		end else begin
			force_debug_reset_bit <= wr_force;
			case (rst_state)
				PFPC_RST_IDLE: begin
					sys_rst_b_o <= 1'b1;
					if (!por_b_s || force_debug_reset_bit) begin
						rst_state    <= PFPC_RST_HOLD;
						hold_is_mode <= 1'b1;
						hold_cnt     <= 8'h00;
						sys_rst_b_o  <= 1'b0;
					end else if (ext_rst_req) begin
						rst_state    <= PFPC_RST_HOLD;
						hold_is_mode <= 1'b0;
						hold_cnt     <= 8'h00;
						sys_rst_b_o  <= 1'b0;
					end
				end
				PFPC_RST_HOLD: begin
					sys_rst_b_o <= 1'b0;
					if (!por_b_s || ext_rst_req) begin
						hold_cnt <= 8'h00;
					end else if (hold_cnt == 8'(PFPC_RST_HOLD_CYC - 1)) begin
						rst_state <= PFPC_RST_SAMPLE;
					end else begin
						hold_cnt <= hold_cnt + 8'h01;
					end
				end
				PFPC_RST_SAMPLE: begin
					// rising edge of internal reset: low selects background unless the reset pin caused the reset
					sys_rst_b_o              <= 1'b1;
					background_debug_state_o <= hold_is_mode & ~mode_select_input;
					por_seen                 <= 1'b1;
					rst_state                <= PFPC_RST_IDLE;
				end
				default: rst_state <= PFPC_RST_IDLE;
			endcase
		end
	end

	// ==================================================
	// debug link bit tick: one pulse every sixteen cycles
	logic [3:0] bit_cnt;
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || !debug_pin_enable) begin
			bit_cnt          <= 4'h0;
			debug_bit_tick_o <= 1'b0;
		end else begin
			bit_cnt          <= bit_cnt + 4'h1;
			debug_bit_tick_o <= bit_cnt == 4'(PFPC_BIT_CYC - 1);
		end
	end

	// ==================================================
	// shared pin muxing by priority
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			debug_mode_select_pin_o    <= 1'b0;
			debug_mode_select_pin_oe_o <= 1'b0;
			port_a_bit_four_o          <= 1'b1;
			port_a_bit_five_o          <= 1'b1;
			debug_rx_o                 <= 1'b1;
			reset_pin_is_reset_o       <= 1'b0;
		end else begin
			reset_pin_is_reset_o <= reset_pin_enable;
			// port value only seen when no higher function owns the pin
			port_a_bit_five_o <= (reset_pin_enable | irq_en_i | tclk_en_i) ? 1'b1 : reset_pin_s;
			debug_rx_o        <= debug_pin_enable ? mode_select_input : 1'b1;
			port_a_bit_four_o <= debug_pin_enable ? 1'b1 : mode_select_input;
			if (!sys_rst_b_o) begin
				// pin only listened to while reset runs
				debug_mode_select_pin_oe_o <= 1'b0;
				debug_mode_select_pin_o    <= 1'b0;
			end else if (debug_pin_enable) begin
				// open drain low, plus short driven-high speedup pulses
				debug_mode_select_pin_oe_o <= bdc_drive_i;
				debug_mode_select_pin_o    <= bdc_drive_level_i;
			end else if (comparator_output_en_i) begin
				debug_mode_select_pin_oe_o <= 1'b1;
				debug_mode_select_pin_o    <= comparator_output_i;
			end else begin
				debug_mode_select_pin_oe_o <= port_a_bit_four_oe_i;
				debug_mode_select_pin_o    <= port_a_bit_four_data_i;
			end
		end
	end

	// ==================================================
	// per-pin pull gating; shared pins forced on by their enables
	logic [13:0] forced;
	logic [13:0] pull_on_n;
	logic [13:0] pull_dn_n;
	always_comb begin
		forced = 14'h0000;
		forced[PFPC_PIN_RESET_SHARED] = reset_pin_enable;
		forced[PFPC_PIN_DEBUG_SHARED] = debug_pin_enable;
	end

	genvar gi;
	generate
		for (gi = 0; gi < PFPC_NPINS; gi++) begin : g_pull
			pfpc_pull_gate u_pg (
				.pull_en_i   (pull_en[gi]),
				.port_oe_i   (pin_req_i.port_oe[gi]),
				.periph_oe_i (pin_req_i.periph_oe[gi]),
				.analog_i    (pin_req_i.analog_en[gi]),
				.kbi_rise_i  (pin_req_i.kbi_rising[gi]),
				.forced_i    (forced[gi]),
				.pull_on_o   (pull_on_n[gi]),
				.pull_down_o (pull_dn_n[gi])
			);
		end
	endgenerate

	// registered pad controls
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			pad_ctl_o     <= '0;
			out_only_en_o <= 1'b0;
		end else begin
			pad_ctl_o.pull_on   <= pull_on_n;
			pad_ctl_o.pull_down <= pull_dn_n;
			pad_ctl_o.drive_hi  <= drive_hi;
			pad_ctl_o.slew_en   <= slew_en;
			out_only_en_o       <= out_only_en;
		end
	end

	// ==================================================
	// register read, data one cycle after the strobe
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				PFPC_REG_SYSOPT:   rdata_o <= {6'h00, debug_pin_enable, reset_pin_enable};
				PFPC_REG_FORCE_RST: rdata_o <= 8'h00;
				PFPC_REG_STATUS:   rdata_o <= {5'h00, por_seen, background_debug_state_o, sys_rst_b_o};
				PFPC_REG_PULL_EN:  rdata_o <= pull_en[7:0];
				PFPC_REG_DRIVE_HI: rdata_o <= drive_hi[7:0];
				PFPC_REG_SLEW_EN:  rdata_o <= slew_en[7:0];
				PFPC_REG_OUT_ONLY: rdata_o <= {out_only_en, drive_hi[13], slew_en[13], pull_en[12:8]};
				default:           rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

endmodule // pfpc_top

// ---- verification/pfpc_top_sva.sv ----
// checker for the pin function and pad control block
`timescale 1ns/1ps
module pfpc_top_sva
	import pfpc_pkg::*;
(
	input wire logic          ref_clk_i,
	input wire logic          rst_b_i,
	input wire logic          por_b_i,
	input wire logic [3:0]    addr_i,
	input wire logic [7:0]    wdata_i,
	input wire logic          wr_i,
	input wire logic          rd_i,
	input wire logic [7:0]    rdata_o,
	input wire pfpc_pin_req_t pin_req_i,
	input wire pfpc_pad_ctl_t pad_ctl_o,
	input wire logic          sys_rst_b_o,
	input wire logic          reset_pin_is_reset_o,
	input wire logic          debug_bit_tick_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);

	// ==================================================
	// helpers
	// pins without a forced pull (debug pin 4, reset pin 5 excluded)
	localparam logic [13:0] FREE = 14'h3fcf;
	wire [13:0]  gate = pin_req_i.port_oe | pin_req_i.periph_oe | pin_req_i.analog_en;
	logic [7:0]  low_cnt;
	// length of the current low stretch of the system reset, saturating
	always_ff @(posedge ref_clk_i) begin
		if (!rst_b_i || sys_rst_b_o)
			low_cnt <= 8'h00;
		else if (low_cnt != 8'hff)
			low_cnt <= low_cnt + 8'h01;
	end
	sequence quiet15;
		!debug_bit_tick_o [*8] ##1 !debug_bit_tick_o [*7];
	endsequence
	sequence force_write;
		wr_i && addr_i == PFPC_REG_FORCE_RST && wdata_i[PFPC_BIT_FORCE_DBG] && sys_rst_b_o;
	endsequence

	// ==================================================
	// assertions
	read_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data not idle");
	reset_sticky_a: assert property (reset_pin_is_reset_o && por_b_i && $past(por_b_i) && $past(por_b_i, 2)
		&& $past(por_b_i, 3) |=> reset_pin_is_reset_o) else $error("reset pin function lost");
	reset_pull_a: assert property (reset_pin_is_reset_o && $past(reset_pin_is_reset_o)
		|-> pad_ctl_o.pull_on[PFPC_PIN_RESET_SHARED]) else $error("reset pin pullup off");
	debug_pull_a: assert property (debug_bit_tick_o |-> pad_ctl_o.pull_on[PFPC_PIN_DEBUG_SHARED])
		else $error("debug pin pullup off");
	bit_time_a: assert property (debug_bit_tick_o |=> quiet15)
		else $error("bit tick too early");
	pull_gate_a: assert property ((pad_ctl_o.pull_on & $past(gate) & FREE) == 14'h0000)
		else $error("pullup on while pin driven or analog");
	pull_down_a: assert property ((pad_ctl_o.pull_down & ~$past(pin_req_i.kbi_rising)) == 14'h0000)
		else $error("pulldown without rising edge use");
	reset_hold_a: assert property ($rose(sys_rst_b_o) |-> low_cnt >= 8'h18)
		else $error("system reset released early");
	force_reset_a: assert property (force_write |-> ##2 !sys_rst_b_o)
		else $error("forced reset missing");
endmodule // pfpc_top_sva

bind pfpc_top pfpc_top_sva u_pfpc_top_sva (.ref_clk_i, .rst_b_i, .por_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .pin_req_i, .pad_ctl_o, .sys_rst_b_o, .reset_pin_is_reset_o, .debug_bit_tick_o);

// ---- verification/pfpc_board_model.sv ----
// board and debug host model for the shared reset and debug pins
`timescale 1ns/1ps
module pfpc_board_model (
	input  wire logic ref_clk_i,
	input  wire logic pin_o_i,
	input  wire logic pin_oe_i,
	input  wire logic pull4_i,
	input  wire logic pull5_i,
	input  wire logic host_low_i,
	input  wire logic press_i,
	output logic      ms_pin_o,
	output logic      rst_pin_o
);
	logic flip = 1'b0;
	// ==================================================
	// undriven lines without pullup float: toggle so no value is trusted
	always_ff @(posedge ref_clk_i) begin
		flip <= ~flip;
	end
	// device drive wins, host pulls low, pullup gives high
	assign ms_pin_o  = pin_oe_i ? pin_o_i : host_low_i ? 1'b0 : pull4_i ? 1'b1 : flip;
	assign rst_pin_o = press_i ? 1'b0 : pull5_i ? 1'b1 : flip;
endmodule // pfpc_board_model

// ---- verification/pfpc_top_tb.sv ----
// self-checking testbench for the pin function and pad control block
`timescale 1ns/1ps
module pfpc_top_tb
	import pfpc_pkg::*;
;
	logic          ref_clk_i = 1'b0;
	logic          rst_b_i = 1'b0;
	logic          por_b_i = 1'b0;
	logic [3:0]    addr_i = 4'h0;
	logic [7:0]    wdata_i = 8'h00;
	logic          wr_i = 1'b0;
	logic          rd_i = 1'b0;
	logic          bdc_drive_i, bdc_drive_level_i, cmp_en, cmp_out, pa4_oe, pa4_d, host_low, press;
	pfpc_pin_req_t pin_req_i = '0;
	pfpc_pad_ctl_t pad_ctl_o;
	logic [7:0]    rdata_o, p, d, s;
	logic [63:0]   r;
	logic          reset_pin_i, is_rst, ms_pin, ms_o, ms_oe, tick, sys_rst_b_o, bg, oo_en;
	logic          pa5, pa4_o, drx;
	logic          irq_en = 1'b0;
	int            err_count = 0;
	int            n_tests = 0;
	int            n;

	pfpc_top u_pfpc_top (.ref_clk_i, .rst_b_i, .por_b_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.reset_pin_i, .irq_en_i(irq_en), .tclk_en_i(1'b0), .reset_pin_is_reset_o(is_rst), .port_a_bit_five_o(pa5),
		.debug_mode_select_pin_i(ms_pin), .debug_mode_select_pin_o(ms_o), .debug_mode_select_pin_oe_o(ms_oe),
		.bdc_drive_i, .bdc_drive_level_i, .comparator_output_en_i(cmp_en), .comparator_output_i(cmp_out),
		.port_a_bit_four_oe_i(pa4_oe), .port_a_bit_four_data_i(pa4_d), .port_a_bit_four_o(pa4_o), .debug_rx_o(drx),
		.debug_bit_tick_o(tick), .pin_req_i, .pad_ctl_o, .sys_rst_b_o, .background_debug_state_o(bg),
		.out_only_en_o(oo_en));
	pfpc_board_model u_pfpc_board_model (.ref_clk_i, .pin_o_i(ms_o), .pin_oe_i(ms_oe),
		.pull4_i(pad_ctl_o.pull_on[4]), .pull5_i(pad_ctl_o.pull_on[5]), .host_low_i(host_low),
		.press_i(press), .ms_pin_o(ms_pin), .rst_pin_o(reset_pin_i));

	// ==================================================
	// clock, 4 ns period
	always #2 ref_clk_i = ~ref_clk_i;

	// ==================================================
	// helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= v;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1 chk({8'h00, rdata_o}, {8'h00, exp});
	endtask
	// bounded wait for the end of the internal reset stretch
	task automatic wait_run();
		n = 0;
		while (sys_rst_b_o !== 1'b1 && n < 300) begin
			cyc(1);
			n++;
		end
		chk(16'(sys_rst_b_o), 16'h0001);
	endtask
	// pulls follow enables, except where driven or analog; forced pins always on
	function automatic logic [13:0] exp_pull(input logic [13:0] en, input pfpc_pin_req_t q, input logic [13:0] f);
		return (en & ~(q.port_oe | q.periph_oe | q.analog_en) & ~f) | f;
	endfunction
	function automatic logic [13:0] exp_down(input logic [13:0] en, input pfpc_pin_req_t q, input logic [13:0] f);
		return en & ~(q.port_oe | q.periph_oe | q.analog_en) & q.kbi_rising & ~f;
	endfunction
	task automatic close_out();
		$display("compares %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ==================================================
	// watchdog: the whole run needs well under 5000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		err_count++;
		close_out();
	end

	// ==================================================
	// main sequence
	initial begin
		{bdc_drive_i, bdc_drive_level_i, cmp_en, cmp_out, pa4_oe, pa4_d, host_low, press} = 8'h00;
		void'($urandom(32'h146bc998));
		cyc(10);
		rst_b_i <= 1'b1;
		por_b_i <= 1'b1;
		wait_run();
		chk(16'(is_rst), 16'h0000);
		chk(16'(oo_en), 16'h0000);
		chk(16'(bg), 16'h0000);
		chk(16'(pad_ctl_o.pull_on), 16'h0010);
		chk(16'({pad_ctl_o.drive_hi, 2'b00}) | 16'(pad_ctl_o.slew_en), 16'h2000);
		rd(PFPC_REG_SYSOPT, 8'h02);
		rd(PFPC_REG_OUT_ONLY, 8'h20);
		rd(4'h3, 8'h00);
		$display("test defaults done");
		// random pad settings under random pin requests, first ones with none
		for (int i = 0; i < 24; i++) begin
			r = {$urandom, $urandom};
			p = 8'($urandom);
			d = 8'($urandom);
			s = 8'($urandom);
			wr(PFPC_REG_PULL_EN, p);
			wr(PFPC_REG_DRIVE_HI, d);
			wr(PFPC_REG_SLEW_EN, s);
			pin_req_i <= (i < 2) ? 56'h0 : r[55:0];
			cyc(3);
			chk(16'(pad_ctl_o.pull_on), 16'(exp_pull({6'h00, p}, pin_req_i, 14'h0010)));
			chk(16'(pad_ctl_o.pull_down), 16'(exp_down({6'h00, p}, pin_req_i, 14'h0010)));
			chk({pad_ctl_o.drive_hi[7:0], pad_ctl_o.slew_en[7:0]}, {d, s});
		end
		rd(PFPC_REG_PULL_EN, p);
		wr(PFPC_REG_OUT_ONLY, 8'hc0);
		cyc(3);
		chk({oo_en, pad_ctl_o.drive_hi[13], pad_ctl_o.slew_en[13]}, 16'h0006);
		pin_req_i <= '0;
		$display("test pads done");
		// reset pin function, sticky, with pullup, and never into background
		// pull the reset pin up first so a floating line cannot reset us on enable
		wr(PFPC_REG_PULL_EN, 8'h20);
		cyc(4);
		wr(PFPC_REG_SYSOPT, 8'h03);
		cyc(2);
		chk({is_rst, pad_ctl_o.pull_on[5]}, 16'h0003);
		wr(PFPC_REG_SYSOPT, 8'h02);
		cyc(2);
		chk(16'(is_rst), 16'h0001);
		host_low <= 1'b1;
		press <= 1'b1;
		cyc(6);
		chk(16'(sys_rst_b_o), 16'h0000);
		press <= 1'b0;
		wait_run();
		chk(16'(bg), 16'h0000);
		por_b_i <= 1'b0;
		cyc(5);
		por_b_i <= 1'b1;
		wait_run();
		chk({is_rst, bg}, 16'h0001);
		$display("test reset pin done");
		// forced debug reset, mode select high then low
		for (int k = 0; k < 2; k++) begin
			host_low <= k[0];
			wr(PFPC_REG_FORCE_RST, 8'h01);
			cyc(2);
			chk(16'(sys_rst_b_o), 16'h0000);
			wait_run();
			chk(16'(bg), 16'(k));
			rd(PFPC_REG_STATUS, {5'h00, 1'b1, k[0], 1'b1});
		end
		host_low <= 1'b0;
		n = 0;
		repeat (160) begin
			cyc(1);
			n += int'(tick === 1'b1);
		end
		chk(16'(n), 16'h000a);
		bdc_drive_i <= 1'b1;
		bdc_drive_level_i <= 1'b1;
		cyc(3);
		chk({ms_oe, ms_o}, 16'h0003);
		bdc_drive_i <= 1'b0;
		$display("test debug pin done");
		// alternate functions after releasing the debug pin
		wr(PFPC_REG_SYSOPT, 8'h00);
		{cmp_en, cmp_out, pa4_oe, pa4_d} <= 4'he;
		cyc(3);
		chk({ms_oe, ms_o, pad_ctl_o.pull_on[4]}, 16'h0006);
		cmp_en <= 1'b0;
		irq_en <= 1'b1;
		cyc(3);
		chk({ms_oe, ms_o}, 16'h0002);
		cyc(2);
		chk({pa4_o, drx, pa5}, 16'h0003);
		$display("test sharing done");
		close_out();
	end
endmodule // pfpc_top_tb
